// file: logic/encoder_cmd_pkg.sv
package encoder_cmd_pkg;
    // status codes
    localparam logic [7:0] ST_OK        = 8'h00;
    localparam logic [7:0] ST_INIT_BASE = 8'h01; // 01h..06h, one per init fault
    localparam logic [7:0] ST_WATCHDOG  = 8'h07;
    localparam logic [7:0] ST_PARITY    = 8'h09;
    localparam logic [7:0] ST_CHECKSUM  = 8'h0A;
    localparam logic [7:0] ST_UNKNOWN   = 8'h0B;
    localparam logic [7:0] ST_LENGTH    = 8'h0C;
    localparam logic [7:0] ST_BADARG    = 8'h0D;
    localparam logic [7:0] ST_PROTECTED = 8'h0E;
    localparam logic [7:0] ST_BADCODE   = 8'h0F;
    localparam logic [7:0] ST_FIXSIZE   = 8'h10;
    localparam logic [7:0] ST_ADDRRANGE = 8'h11;
    localparam logic [7:0] ST_NOFIELD   = 8'h12;
    localparam logic [7:0] ST_ANAMON    = 8'h1C;
    localparam logic [7:0] ST_CURRENT   = 8'h1D;
    localparam logic [7:0] ST_TEMP      = 8'h1E;
    localparam logic [7:0] ST_SPEED     = 8'h1F;
    // command bytes
    localparam logic [7:0] CMD_RDPOS  = 8'h42;
    localparam logic [7:0] CMD_SETPOS = 8'h43;
    localparam logic [7:0] CMD_ANALOG = 8'h44;
    localparam logic [7:0] CMD_RDCNT  = 8'h46;
    localparam logic [7:0] CMD_INCCNT = 8'h47;
    localparam logic [7:0] CMD_CLRCNT = 8'h49;
    localparam logic [7:0] CMD_RDDAT  = 8'h4A;
    localparam logic [7:0] CMD_STDAT  = 8'h4B;
    localparam logic [7:0] CMD_FSTAT  = 8'h4C;
    localparam logic [7:0] CMD_CREATE = 8'h4D;
    localparam logic [7:0] CMD_FREE   = 8'h4E;
    localparam logic [7:0] CMD_CHCODE = 8'h4F;
    localparam logic [7:0] CMD_STATUS = 8'h50;
    localparam logic [7:0] CMD_TYPE   = 8'h52;
    localparam logic [7:0] CMD_RESET  = 8'h53;
    localparam logic [7:0] CMD_ADDR   = 8'h55;
    localparam logic [7:0] CMD_SERIAL = 8'h56;
    localparam logic [7:0] CMD_IFCFG  = 8'h57;
    // misc values
    localparam logic [7:0] KEY_RESET   = 8'h55; // protection key after reset
    localparam logic [7:0] CODE_RESET  = 8'h55; // field access code after reset
    localparam logic [7:0] CHAN_TEMP   = 8'h48;
    localparam logic [7:0] CHAN_ANALOG = 8'hF0;
    localparam logic [7:0] ERR_FLAG    = 8'h80; // or-ed into echoed command byte
    localparam logic [7:0] ADDR_RESET  = 8'h40;
    localparam logic [7:0] MODE_RESET  = 8'hE4;
    localparam logic [2:0] LEN_BAD     = 3'd7;  // marks an unknown command

    typedef enum logic [1:0] {BOOT, RECV, SEND} phase_t;

    // argument bytes each command needs; LEN_BAD if unknown
    function automatic logic [2:0] argsNeeded(input logic [7:0] c);
        unique case (c)
            CMD_RDPOS, CMD_RDCNT, CMD_INCCNT, CMD_FREE: return 3'd0;
            CMD_STATUS, CMD_TYPE, CMD_RESET, CMD_SERIAL: return 3'd0;
            CMD_ANALOG, CMD_CLRCNT, CMD_FSTAT, CMD_IFCFG: return 3'd1;
            CMD_SETPOS, CMD_RDDAT, CMD_ADDR: return 3'd2;
            CMD_CREATE, CMD_CHCODE: return 3'd3;
            CMD_STDAT: return 3'd4;
            default: return LEN_BAD;
        endcase
    endfunction
endpackage

// file: logic/encoder_command_status_unit.sv
// Summary of operation
// [R01] status 00h when no fault present
// [R02] init faults reported as 01h to 06h
// [R03] watchdog reset reported as 07h
// [R04] parity 09h, frame checksum 0Ah
// [R05] unknown command 0Bh, wrong length 0Ch
// [R06] disallowed argument value gives 0Dh
// [R07] protected field 0Eh, wrong code 0Fh
// [R08] resizing a fixed field gives 10h
// [R09] word outside field 11h, missing 12h
// [R10] speed too high for position: 1Fh
// [R11] monitoring faults 1Ch, 1Dh, 1Eh
// [R12] decode position, analog, counter, status, misc commands
// [R13] decode data-field commands 4Ah to 4Fh
// [R14] key byte checked on 49h and 55h
// [R15] protection key resets to 55h
// [R16] rejected command changes nothing, code readable
module encoder_command_status_unit
    import encoder_cmd_pkg::*;
#(
    parameter int         NF         = 4,       // number of data fields
    parameter int         WORDS      = 16,      // bytes per data field
    parameter logic [7:0] TYPE_LABEL = 8'hA5,   // arbitrary value
    parameter logic [15:0] SERIAL    = 16'h1234, // arbitrary value
    parameter logic [7:0] VERSION    = 8'h01    // arbitrary value
)(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxParityErr,
    input  wire logic        rxEnd,
    input  wire logic        rxCsumErr,
    input  wire logic        txReady,
    output logic             txValid,
    output logic [7:0]       txData,
    output logic             txLast,
    input  wire logic [14:0] rawPos,
    input  wire logic        speedHigh,
    input  wire logic [7:0]  analogLevel,
    input  wire logic [7:0]  temperature,
    input  wire logic [5:0]  initFault,
    input  wire logic        wdReset,
    input  wire logic        analogMonFault,
    input  wire logic        currentFault,
    input  wire logic        tempFault,
    output logic             encResetPulse,
    output logic [7:0]       devAddr,
    output logic [7:0]       ifMode,
    output logic [7:0]       statusCode
);
    localparam int FW = (NF > 1) ? $clog2(NF) : 1;
    localparam int AW = $clog2(WORDS);

    // the free-memory answer is one byte
    if (NF * WORDS > 255 || NF < 2 || WORDS < 2) $error("NF/WORDS out of range");

    phase_t      phase_r;                 // boot, receive, answer
    logic [7:0]  cmd_r;                   // command byte of current frame
    logic [7:0]  arg_r [4];               // argument bytes
    logic [2:0]  argCnt_r;                // saturates at 5 to flag overlong
    logic        parErr_r;                // parity error seen in frame
    logic [14:0] posOffset_r;             // set-position offset
    logic [15:0] counter_r;
    logic [7:0]  key_r;                   // protection key
    logic [7:0]  statusCode_r;
    logic [7:0]  devAddr_r, ifMode_r;
    logic        encReset_r;
    logic [NF-1:0] fieldExist_r;
    logic [7:0]  fieldSize_r [NF];
    logic [7:0]  fieldCode_r [NF];
    logic [7:0]  mem_r [NF][WORDS];       // data field storage
    logic [7:0]  resp_r [4];              // answer bytes
    logic [1:0]  respLast_r, respIdx_r;
    logic        txValid_r, txLast_r;
    logic [7:0]  txData_r;
    logic [2:0]  monPrev_r;               // for edge detection of monitors

    // shared decode
    wire         frameDone = (phase_r == RECV) && rxEnd;
    wire         fieldOk   = arg_r[0] < 8'(NF);
    wire [FW-1:0] fIdx     = fieldOk ? arg_r[0][FW-1:0] : '0;
    wire         fExists   = fieldOk && fieldExist_r[fIdx];
    wire         fFixed    = fIdx == '0;   // field 0: fixed size, write-protected
    wire [AW-1:0] wIdx     = arg_r[1][AW-1:0];
    wire [14:0]  position  = rawPos + posOffset_r;
    wire [14:0]  newOffset = {arg_r[0][6:0], arg_r[1]} - rawPos;
    wire [2:0]   monNow    = {tempFault, currentFault, analogMonFault};
    wire [2:0]   monRise   = monNow & ~monPrev_r;

    // error of a field access; order: missing, range, protection, code
    function automatic logic [7:0] fieldErr(input logic wr, input logic [7:0] code);
        if (!fExists) return ST_NOFIELD;                          // R09
        if (arg_r[1] >= fieldSize_r[fIdx]) return ST_ADDRRANGE;   // R09
        if (wr && fFixed) return ST_PROTECTED;                    // R07
        if (wr && code != fieldCode_r[fIdx]) return ST_BADCODE;   // R07
        return ST_OK;
    endfunction

    // free memory: whole fields not yet created
    logic [7:0] freeBytes;
    always_comb
    begin
        freeBytes = 8'h00;
        for (int i = 0; i < NF; i++)
            if (!fieldExist_r[i]) freeBytes = freeBytes + 8'(WORDS);
    end

    // command execution, evaluated at frame end
    logic [7:0] err, p0, p1, p2;
    logic [1:0] pLast;
    always_comb
    begin
        err = ST_OK;
        p0 = 8'h00;
        p1 = 8'h00;
        p2 = 8'h00;
        pLast = 2'd0;
        if (parErr_r) err = ST_PARITY;                               // R04
        else if (rxCsumErr) err = ST_CHECKSUM;                       // R04
        else if (argsNeeded(cmd_r) == LEN_BAD) err = ST_UNKNOWN;     // R05
        else if (argCnt_r != argsNeeded(cmd_r)) err = ST_LENGTH;     // R05
        else
        begin
            unique case (cmd_r)                                      // R12 R13
                CMD_RDPOS:
                    if (speedHigh) err = ST_SPEED;                   // R10
                    else
                    begin
                        p0 = {1'b0, position[14:8]};
                        p1 = position[7:0];
                        pLast = 2'd2;
                    end
                CMD_SETPOS:
                    if (arg_r[0][7]) err = ST_BADARG;                // R06
                CMD_ANALOG:
                begin
                    pLast = 2'd1;
                    if (arg_r[0] == CHAN_TEMP) p0 = temperature;
                    else if (arg_r[0] == CHAN_ANALOG) p0 = analogLevel;
                    else err = ST_BADARG;                            // R06
                end
                CMD_RDCNT:
                begin
                    p0 = counter_r[15:8];
                    p1 = counter_r[7:0];
                    pLast = 2'd2;
                end
                CMD_CLRCNT:
                    if (arg_r[0] != key_r) err = ST_BADCODE;         // R14
                CMD_ADDR:
                    if (arg_r[1] != key_r) err = ST_BADCODE;         // R14
                CMD_RDDAT:
                begin
                    err = fieldErr(1'b0, 8'h00);
                    p0 = mem_r[fIdx][wIdx];
                    pLast = 2'd1;
                end
                CMD_STDAT:
                    err = fieldErr(1'b1, arg_r[2]);
                CMD_FSTAT:
                    if (!fExists) err = ST_NOFIELD;                  // R09
                    else
                    begin
                        p0 = fieldSize_r[fIdx];
                        p1 = {7'h00, fFixed};
                        pLast = 2'd2;
                    end
                CMD_CREATE:
                    if (!fieldOk) err = ST_NOFIELD;                  // R09
                    else if (fFixed) err = ST_FIXSIZE;               // R08
                    else if (arg_r[1] == 8'h00 || arg_r[1] > 8'(WORDS))
                        err = ST_BADARG;                             // R06
                CMD_FREE:
                begin
                    p0 = freeBytes;
                    pLast = 2'd1;
                end
                CMD_CHCODE:
                    if (!fExists) err = ST_NOFIELD;
                    else if (arg_r[1] != fieldCode_r[fIdx]) err = ST_BADCODE; // R07
                CMD_STATUS:
                begin
                    p0 = statusCode_r;                               // R16
                    pLast = 2'd1;
                end
                CMD_TYPE:
                begin
                    p0 = TYPE_LABEL;
                    pLast = 2'd1;
                end
                CMD_SERIAL:
                begin
                    p0 = SERIAL[15:8];
                    p1 = SERIAL[7:0];
                    p2 = VERSION;
                    pLast = 2'd3;
                end
                default: ;  // 47h, 53h and 57h answer with the echo only
            endcase
        end
    end
    wire ok = err == ST_OK;  // every device state change below is gated by this

    // frame collection and answer sequencing
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            phase_r <= BOOT;
            argCnt_r <= 3'd0;
            parErr_r <= 1'b0;
            cmd_r <= 8'h00;
            txValid_r <= 1'b0;
            txLast_r <= 1'b0;
            txData_r <= 8'h00;
            respIdx_r <= 2'd0;
            respLast_r <= 2'd0;
        end
        else
        begin
            unique case (phase_r)
                BOOT: phase_r <= RECV;
                RECV:
                    if (frameDone)
                    begin
                        // answer: echo (error flag on reject) then payload
                        resp_r[0] <= ok ? p0 : err;
                        resp_r[1] <= p1;
                        resp_r[2] <= p2;
                        respLast_r <= ok ? pLast : 2'd1;
                        txData_r <= ok ? cmd_r : (cmd_r | ERR_FLAG);
                        txLast_r <= ok && pLast == 2'd0;
                        txValid_r <= 1'b1;
                        respIdx_r <= 2'd0;
                        argCnt_r <= 3'd0;
                        parErr_r <= 1'b0;
                        phase_r <= SEND;
                    end
                    else if (rxValid)
                    begin
                        // half duplex: bytes only taken while receiving
                        if (argCnt_r == 3'd0 && cmd_r == 8'h00) cmd_r <= rxData;
                        else if (argCnt_r < 3'd5)
                        begin
                            if (argCnt_r < 3'd4) arg_r[argCnt_r[1:0]] <= rxData;
                            argCnt_r <= argCnt_r + 3'd1;
                        end
                        parErr_r <= parErr_r | rxParityErr;
                    end
                SEND:
                    if (txValid_r && txReady)
                    begin
                        if (txLast_r)
                        begin
                            txValid_r <= 1'b0;
                            txLast_r <= 1'b0;
                            cmd_r <= 8'h00;
                            phase_r <= RECV;
                        end
                        else
                        begin
                            txData_r <= resp_r[respIdx_r];
                            txLast_r <= respIdx_r + 2'd1 == respLast_r;
                            respIdx_r <= respIdx_r + 2'd1;
                        end
                    end
                default: phase_r <= RECV;
            endcase
        end
    end

    // device state changed only by accepted commands
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            posOffset_r <= 15'h0000;
            counter_r <= 16'h0000;
            key_r <= KEY_RESET;                                      // R15
            devAddr_r <= ADDR_RESET;
            ifMode_r <= MODE_RESET;
            encReset_r <= 1'b0;
            fieldExist_r <= NF'(1);
            for (int i = 0; i < NF; i++)
            begin
                fieldSize_r[i] <= 8'(WORDS);
                fieldCode_r[i] <= CODE_RESET;
            end
        end
        else
        begin
            encReset_r <= frameDone && ok && cmd_r == CMD_RESET;
            if (frameDone && ok)                                     // R16
            begin
                unique case (cmd_r)
                    CMD_SETPOS: posOffset_r <= newOffset;
                    CMD_INCCNT: counter_r <= counter_r + 16'h0001;
                    CMD_CLRCNT: counter_r <= 16'h0000;               // R14
                    CMD_ADDR: devAddr_r <= arg_r[0];                 // R14
                    CMD_IFCFG: ifMode_r <= arg_r[0];
                    CMD_STDAT: mem_r[fIdx][wIdx] <= arg_r[3];        // R13
                    CMD_CREATE:
                    begin
                        fieldExist_r[fIdx] <= 1'b1;
                        fieldSize_r[fIdx] <= arg_r[1];
                        fieldCode_r[fIdx] <= arg_r[2];
                    end
                    CMD_CHCODE: fieldCode_r[fIdx] <= arg_r[2];
                    default: ;
                endcase
            end
        end
    end

    // status code: boot result, then last error or monitor event
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            statusCode_r <= ST_OK;
            monPrev_r <= 3'b000;
        end
        else
        begin
            monPrev_r <= monNow;
            if (phase_r == BOOT)
            begin
                statusCode_r <= ST_OK;                               // R01
                if (wdReset) statusCode_r <= ST_WATCHDOG;            // R03
                for (int i = 5; i >= 0; i--)
                    if (initFault[i]) statusCode_r <= ST_INIT_BASE + 8'(i); // R02
            end
            else if (frameDone && !ok) statusCode_r <= err;          // R16
            else if (frameDone && cmd_r == CMD_RESET) statusCode_r <= ST_OK;
            else if (monRise[2]) statusCode_r <= ST_TEMP;            // R11
            else if (monRise[1]) statusCode_r <= ST_CURRENT;         // R11
            else if (monRise[0]) statusCode_r <= ST_ANAMON;          // R11
        end
    end

    assign txValid       = txValid_r;
    assign txData        = txData_r;
    assign txLast        = txLast_r;
    assign encResetPulse = encReset_r;
    assign devAddr       = devAddr_r;
    assign ifMode        = ifMode_r;
    assign statusCode    = statusCode_r;
endmodule

// file: testbench/drive_model.sv
module drive_model
    import encoder_cmd_pkg::*;
(
    input  wire logic       clk,
    output logic            rxValid,
    output logic [7:0]      rxData,
    output logic            rxParityErr,
    output logic            rxEnd,
    output logic            rxCsumErr,
    output logic            txReady,
    input  wire logic       txValid,
    input  wire logic [7:0] txData,
    input  wire logic       txLast
);
    timeunit 1ns;
    timeprecision 1ns;

    typedef logic [7:0] bytes_t [$];

    bytes_t ans;  // answer bytes taken
    logic   slow; // stall every other cycle
    logic   hung; // answer missing or unfinished

    // idle line, ready to take answers
    initial
    begin
        rxValid = 1'b0;
        rxData = 8'h00;
        rxParityErr = 1'b0;
        rxEnd = 1'b0;
        rxCsumErr = 1'b0;
        txReady = 1'b1;
        slow = 1'b0;
        hung = 1'b0;
    end

    // one frame out, whole answer back; bounded so a silent unit cannot hang us
    task automatic frame(input bytes_t b, input int parAt, input logic csum);
        ans = {};
        hung = 1'b1;
        foreach (b[i])
        begin
            @(negedge clk);
            rxValid = 1'b1;
            rxData = b[i];
            rxParityErr = (i == parAt);
        end
        @(negedge clk);
        rxValid = 1'b0;
        rxParityErr = 1'b0;
        rxData = ~rxData; // no stale byte left on the line
        rxEnd = 1'b1;
        rxCsumErr = csum;
        @(negedge clk);
        rxEnd = 1'b0;
        rxCsumErr = 1'b0;
        for (int n = 0; n < 40 && hung; n++)
        begin
            rxData = ~rxData;
            txReady = slow ? ~txReady : 1'b1;
            // ready stays put until the next falling edge, so this byte is taken
            if (txValid && txReady)
            begin
                ans.push_back(txData);
                if (txLast)
                    hung = 1'b0;
            end
            @(negedge clk);
        end
    endtask
endmodule

// file: testbench/encoder_status_props.sv
module encoder_status_props
    import encoder_cmd_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       rxEnd,
    input wire logic       txReady,
    input wire logic       txValid,
    input wire logic [7:0] txData,
    input wire logic       txLast,
    input wire logic [5:0] initFault,
    input wire logic       wdReset,
    input wire logic       analogMonFault,
    input wire logic       encResetPulse,
    input wire logic [7:0] devAddr,
    input wire logic [7:0] statusCode
);
    timeunit 1ns;
    timeprecision 1ns;
    // high while the next byte shown opens an answer
    logic firstPend_r;

    // follow answer boundaries from the handshake alone
    always_ff @(posedge clk)
    begin
        if (reset)
            firstPend_r <= 1'b1;
        else if (txValid && txReady)
            firstPend_r <= txLast;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    reset_vals_a: assert property ($past(reset) |-> !txValid && !txLast &&
        !encResetPulse && devAddr == 8'h40 && statusCode == 8'h00)
        else $error("outputs wrong after reset");
    answer_delay_a: assert property (rxEnd && !txValid && !$past(reset) |=> txValid)
        else $error("answer not started one cycle after frame end");
    answer_hold_a: assert property (txValid && !txReady |=>
        txValid && $stable(txData) && $stable(txLast))
        else $error("answer byte moved while stalled");
    reject_status_a: assert property (firstPend_r && txValid && txReady && txData[7] |=>
        txValid && txLast && txData == statusCode)
        else $error("reject answer lacks stored status");
    pulse_single_a: assert property (encResetPulse |=> !encResetPulse)
        else $error("reset pulse longer than one cycle");
    boot_ok_a: assert property ($past(reset) && initFault == 6'h00 && !wdReset |=>
        statusCode == 8'h00)
        else $error("clean boot not reported as no fault");
    boot_init_a: assert property ($past(reset) && initFault == 6'h04 && !wdReset |=>
        statusCode == 8'h03)
        else $error("init fault code wrong");
    boot_wd_a: assert property ($past(reset) && initFault == 6'h00 && wdReset |=>
        statusCode == 8'h07)
        else $error("watchdog boot code wrong");
    mon_analog_a: assert property ($rose(analogMonFault) && !rxEnd && !$past(reset)
        |-> ##[1:2] statusCode == 8'h1C)
        else $error("analog monitor code not set");
    addr_change_a: assert property ($changed(devAddr) && !$past(reset) |-> $past(rxEnd))
        else $error("address moved outside a command");

    reject_seen_c: cover property (firstPend_r && txValid && txData[7]);
    stall_seen_c: cover property (txValid && !txReady);
    pulse_seen_c: cover property (encResetPulse);
endmodule

bind encoder_command_status_unit encoder_status_props chk (.clk, .reset, .rxEnd, .txReady,
    .txValid, .txData, .txLast, .initFault, .wdReset, .analogMonFault, .encResetPulse,
    .devAddr, .statusCode);

// file: testbench/testbench.sv
module testbench
    import encoder_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef logic [7:0] bytes_t [$];
    localparam logic [7:0]  TYPE_V = 8'h3E;   // arbitrary value
    localparam logic [15:0] SER_V  = 16'hBEEF; // arbitrary value
    localparam logic [7:0]  VER_V  = 8'h02;   // arbitrary value

    logic        clk, reset, rxValid, rxParityErr, rxEnd, rxCsumErr, txReady;
    logic        txValid, txLast, speedHigh, wdReset, encResetPulse;
    logic        analogMonFault, currentFault, tempFault;
    logic [7:0]  rxData, txData, analogLevel, temperature, devAddr, ifMode, statusCode;
    logic [14:0] rawPos;
    logic [5:0]  initFault;
    int          fails, samplesChecked;

    encoder_command_status_unit #(.TYPE_LABEL(TYPE_V), .SERIAL(SER_V), .VERSION(VER_V)) dut (
        .clk, .reset, .rxValid, .rxData, .rxParityErr, .rxEnd, .rxCsumErr, .txReady,
        .txValid, .txData, .txLast, .rawPos, .speedHigh, .analogLevel, .temperature,
        .initFault, .wdReset, .analogMonFault, .currentFault, .tempFault, .encResetPulse,
        .devAddr, .ifMode, .statusCode);
    drive_model master (.clk, .rxValid, .rxData, .rxParityErr, .rxEnd, .rxCsumErr,
        .txReady, .txValid, .txData, .txLast);

    // free-running clock, 100 ns period
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic close_out();
        $display("compared %0d, mismatched %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // reset held five cycles; boot cycle samples the fault levels
    task automatic doReset(input logic [5:0] f, input logic w);
        @(negedge clk);
        reset = 1'b1;
        initFault = f;
        wdReset = w;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        initFault = 6'h00;
        wdReset = 1'b0;
    endtask

    // send a frame and compare the whole answer, length first
    task automatic run(input bytes_t b, input bytes_t e, input int par = -1,
                       input logic cs = 1'b0);
        master.frame(b, par, cs);
        if (master.hung)
        begin
            fails++;
            close_out();
        end
        else
        begin
            check(16'(master.ans.size()), 16'(e.size()));
            foreach (e[i])
                check(master.ans[i], e[i]);
        end
    endtask

    // rejected frame: flagged echo, code, and the code kept as status
    task automatic bad(input bytes_t b, input logic [7:0] c, input int par = -1,
                       input logic cs = 1'b0);
        run(b, '{b[0] | 8'h80, c}, par, cs);
        check(statusCode, c);
    endtask

    task automatic bootCodes();
        doReset(6'h00, 1'b0);
        check(statusCode, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            doReset(6'h01 << i, 1'b0);
            check(statusCode, 8'h01 + 8'(i));
        end
        doReset(6'h00, 1'b1);
        run('{8'h50}, '{8'h50, 8'h07});
        run('{8'h53}, '{8'h53});
        run('{8'h50}, '{8'h50, 8'h00});
    endtask

    task automatic protoErrors();
        bad('{8'h44, 8'hF0}, 8'h09, 1);
        bad('{8'h42}, 8'h0A, -1, 1'b1);
        bad('{8'h41}, 8'h0B);
        bad('{8'h50, 8'h00}, 8'h0C);
        bad('{8'h42, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05}, 8'h0C);
        bad('{8'h44, 8'h00}, 8'h0D);
        bad('{8'h43, 8'h80, 8'h00}, 8'h0D);
        run('{8'h50}, '{8'h50, 8'h0D});
    endtask

    // stalled answers while fields are built and guarded
    task automatic fieldOps();
        master.slow = 1'b1;
        bad('{8'h4B, 8'h00, 8'h00, 8'h55, 8'h11}, 8'h0E);
        bad('{8'h4D, 8'h00, 8'h04, 8'h55}, 8'h10);
        bad('{8'h4A, 8'h01, 8'h00}, 8'h12);
        bad('{8'h4A, 8'h04, 8'h00}, 8'h12);
        bad('{8'h4D, 8'h01, 8'h00, 8'h55}, 8'h0D);
        run('{8'h4D, 8'h01, 8'h04, 8'h55}, '{8'h4D});
        run('{8'h4C, 8'h01}, '{8'h4C, 8'h04, 8'h00});
        run('{8'h4B, 8'h01, 8'h03, 8'h55, 8'h5A}, '{8'h4B});
        bad('{8'h4B, 8'h01, 8'h03, 8'h12, 8'hA5}, 8'h0F);
        bad('{8'h4A, 8'h01, 8'h04}, 8'h11);
        run('{8'h4A, 8'h01, 8'h03}, '{8'h4A, 8'h5A});
        run('{8'h4F, 8'h01, 8'h55, 8'h33}, '{8'h4F});
        bad('{8'h4B, 8'h01, 8'h03, 8'h55, 8'hA5}, 8'h0F);
        run('{8'h4E}, '{8'h4E, 8'h20});
        master.slow = 1'b0;
    endtask

    task automatic posCount();
        run('{8'h42}, '{8'h42, 8'h12, 8'h34});
        run('{8'h43, 8'h01, 8'h00}, '{8'h43});
        run('{8'h42}, '{8'h42, 8'h01, 8'h00});
        speedHigh = 1'b1;
        bad('{8'h42}, 8'h1F);
        speedHigh = 1'b0;
        run('{8'h47}, '{8'h47});
        run('{8'h47}, '{8'h47});
        bad('{8'h49, 8'h54}, 8'h0F);
        run('{8'h46}, '{8'h46, 8'h00, 8'h02});
        run('{8'h49, 8'h55}, '{8'h49});
        run('{8'h46}, '{8'h46, 8'h00, 8'h00});
    endtask

    task automatic misc();
        run('{8'h44, 8'hF0}, '{8'h44, 8'h3C});
        run('{8'h44, 8'h48}, '{8'h44, 8'h19});
        run('{8'h52}, '{8'h52, TYPE_V});
        run('{8'h56}, '{8'h56, SER_V[15:8], SER_V[7:0], VER_V});
        bad('{8'h55, 8'h41, 8'h54}, 8'h0F);
        check(devAddr, 8'h40);
        run('{8'h55, 8'h41, 8'h55}, '{8'h55});
        check(devAddr, 8'h41);
        run('{8'h57, 8'hE5}, '{8'h57});
        check(ifMode, 8'hE5);
    endtask

    // each monitor edge sets its own code; level dropped before reading
    task automatic monitors();
        for (int i = 0; i < 3; i++)
        begin
            {tempFault, currentFault, analogMonFault} = 3'b001 << i;
            repeat (3) @(negedge clk);
            check(statusCode, 8'h1C + 8'(i));
            {tempFault, currentFault, analogMonFault} = 3'b000;
            run('{8'h50}, '{8'h50, 8'h1C + 8'(i)});
        end
    endtask

    // every input defined at time zero, then the scenarios in order
    initial
    begin
        fails = 0;
        samplesChecked = 0;
        reset = 1'b1;
        initFault = 6'h00;
        wdReset = 1'b0;
        rawPos = 15'h1234;
        speedHigh = 1'b0;
        analogLevel = 8'h3C;
        temperature = 8'h19;
        {tempFault, currentFault, analogMonFault} = 3'b000;
        bootCodes();
        protoErrors();
        fieldOps();
        posCount();
        misc();
        monitors();
        close_out();
    end
endmodule
